// >>> hdl/mdsh_ctrl.sv
// channel registers, acquisition sequencing and track/reset classification
// assumes cmd words arrive complete from a framer on clk; pins are async
// Notes on behaviour
// - 32 fourteen-bit registers, direct load by address
// - output updates after address and code received
// - power-on clears all 33 registers
// - offset register by acquisition or load
// - low pulse 90..200 ns resets everything
// - low pulse under 90 ns ignored
// - longer low tracks input, defers acquisition
// - acquisition within 16 us, input then code
// - acquired value held until readdressed
// - busy low exactly during acquisition
// - two mode bits select the operation
// - deferred acquisition starts on track rising
`timescale 1ns/1ps
`default_nettype none
`include "mdsh_params.svh"
module mdsh_ctrl #(
	parameter int ACQ_CYC = `MDSH_ACQ_CYC
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rstn,
	// decoded serial word
	input  wire logic                   cmd_valid,
	input  wire mdsh_pkg::mdsh_cmd_t    cmd,
	// pins
	input  wire logic                   track_reset_n,
	output logic                        busy_n,
	// converter side
	input  wire logic [13:0]            adc_code,
	output logic [31:0][13:0]           chan_code,
	output logic [13:0]                 offset_code,
	output logic [31:0]                 follow_input,
	output logic                        offset_channel_output,
	output logic [13:0]                 readback_code,
	output logic                        readback_valid
);
	import mdsh_pkg::*;

	localparam int GL = `MDSH_GLITCH_CYC;
	localparam int RS = `MDSH_RESET_CYC;

	typedef struct packed {
		logic [31:0][13:0] regs;
		logic [13:0]       offs;
		mdsh_state_t       st;
		logic [5:0]        sel;
		logic              rb_after;
		logic [22:0]       acq_cnt;
		logic [7:0]        low_cnt;
		logic              trk_d;
		logic [13:0]       rb;
		logic              rb_v;
	} mdsh_state_all_t;

	// ====================================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync;
	logic       rst_ok;
	logic [1:0] trk_sync;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync <= 2'h0;
			trk_sync <= 2'h3;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
			trk_sync <= {trk_sync[0], track_reset_n};
		end
	end
	assign rst_ok = rst_sync[1];
	logic trk;
	assign trk = trk_sync[1];

	// ====================================================================
	// next state
	mdsh_state_all_t s;
	mdsh_state_all_t next_s;
	logic            soft_rst;
	logic            rise;
	always_comb begin
		next_s = s;
		next_s.rb_v = 1'b0;
		next_s.trk_d = trk;
		rise = trk && !s.trk_d;
		soft_rst = 1'b0;
		// count low time, saturating just past the reset window
		if (!trk) begin
			if (s.low_cnt <= 8'(RS))
				next_s.low_cnt = s.low_cnt + 8'h01;
		end else begin
			next_s.low_cnt = 8'h00;
		end
		// low pulse in window resets; shorter is a glitch
		if (rise && s.low_cnt >= 8'(GL) && s.low_cnt <= 8'(RS))
			soft_rst = 1'b1;
		unique case (s.st)
			MDSH_IDLE: begin
				if (cmd_valid) begin
					unique case (cmd.mode)
						MDSH_LOAD: begin
							// whole word in hand before the register moves
							if (cmd.chan == `MDSH_OFFSET_CH)
								next_s.offs = cmd.code;
							else if (cmd.chan < 6'(`MDSH_NUM_CH))
								next_s.regs[cmd.chan[4:0]] = cmd.code;
						end
						MDSH_RB: begin
							next_s.rb_v = 1'b1;
							next_s.rb = (cmd.chan == `MDSH_OFFSET_CH) ? s.offs
								: s.regs[cmd.chan[4:0]];
						end
						default: begin
							next_s.sel = cmd.chan;
							next_s.rb_after = (cmd.mode == MDSH_ACQ_RB);
							next_s.acq_cnt = 23'h0;
							// low track defers; the input drives the buffer
							next_s.st = trk ? MDSH_ACQ : MDSH_TRACK;
						end
					endcase
				end
			end
			MDSH_TRACK: begin
				// a rise only counts once the low was long enough
				if (rise && s.low_cnt > 8'(RS))
					next_s.st = MDSH_ACQ;
			end
			MDSH_ACQ: begin
				next_s.acq_cnt = s.acq_cnt + 23'h1;
				if (s.acq_cnt == 23'(ACQ_CYC - 1)) begin
					next_s.st = MDSH_IDLE;
					if (s.sel == `MDSH_OFFSET_CH)
						next_s.offs = adc_code;
					else if (s.sel < 6'(`MDSH_NUM_CH))
						next_s.regs[s.sel[4:0]] = adc_code;
					next_s.rb_v = s.rb_after;
					next_s.rb = adc_code;
				end
			end
			default: next_s.st = MDSH_IDLE;
		endcase
		if (soft_rst) begin
			next_s = '0;
			next_s.st = MDSH_IDLE;
			next_s.trk_d = trk;
		end
	end

	// ====================================================================
	// state register; power-on zeroes every channel
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok) begin
			s <= '0;
			s.st <= MDSH_IDLE;
			s.trk_d <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ====================================================================
	// outputs
	logic tracking;
	assign tracking = (s.st == MDSH_TRACK) || (s.st == MDSH_ACQ);
	assign busy_n = (s.st != MDSH_ACQ);
	assign chan_code = s.regs;
	assign offset_code = s.offs;
	assign readback_code = s.rb;
	assign readback_valid = s.rb_v;
	assign offset_channel_output = tracking && (s.sel == `MDSH_OFFSET_CH);
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_follow
			// buffer follows input during track and acquisition
			assign follow_input[gi] = tracking && (s.sel == 6'(gi));
		end
	endgenerate

	// ====================================================================
	// checks
	// acquisition start: idle, pin high, and no pin reset in the same cycle
	sequence acq_start;
		s.st == MDSH_IDLE && cmd_valid && cmd.mode == MDSH_SHA && trk
		&& !soft_rst;
	endsequence

	// busy length counted apart from the sequencer's own counter, so a
	// stuck state or an end counted late shows up; too long for a delay range
	logic [22:0] busy_len;
	always_ff @(posedge clk or negedge rst_ok) begin
		if (!rst_ok)
			busy_len <= 23'h0;
		else if (!busy_n)
			busy_len <= busy_len + 23'h1;
		else
			busy_len <= 23'h0;
	end

	a_busy_window: assert property (
		@(posedge clk) disable iff (!rst_ok)
		acq_start |=> !busy_n) else $error("busy not low");
	a_acq_bound: assert property (
		@(posedge clk) disable iff (!rst_ok)
		!busy_n |-> busy_len < 23'(ACQ_CYC)) else $error("acq long");
	a_follow_acq: assert property (
		@(posedge clk) disable iff (!rst_ok)
		!busy_n && s.sel <= `MDSH_OFFSET_CH
		|-> (|follow_input) || offset_channel_output)
		else $error("buffer not on input");
	a_load_store: assert property (
		@(posedge clk) disable iff (!rst_ok)
		s.st == MDSH_IDLE && cmd_valid && cmd.mode == MDSH_LOAD
		&& cmd.chan < 6'h20 && !soft_rst
		|=> chan_code[$past(cmd.chan[4:0])] == $past(cmd.code))
		else $error("load lost");
	a_glitch_ign: assert property (
		@(posedge clk) disable iff (!rst_ok)
		rise && s.low_cnt < 8'(GL) |-> !soft_rst) else $error("glitch");
	a_reset_win: assert property (
		@(posedge clk) disable iff (!rst_ok)
		rise && s.low_cnt == 8'(RS) |=> offset_code == 14'h0)
		else $error("no reset");
	a_long_noreset: assert property (
		@(posedge clk) disable iff (!rst_ok)
		rise && s.low_cnt > 8'(RS) |-> !soft_rst) else $error("reset");
	a_track_hold: assert property (
		@(posedge clk) disable iff (!rst_ok)
		s.st == MDSH_TRACK && !rise |=> s.st == MDSH_TRACK)
		else $error("track");
	a_hold_val: assert property (
		@(posedge clk) disable iff (!rst_ok)
		s.st == MDSH_IDLE && !cmd_valid && !soft_rst
		|=> $stable(chan_code)) else $error("drift");
endmodule // mdsh_ctrl
`default_nettype wire

// >>> pkg/mdsh_params.svh
// timing counts, field layout and reset values for the dac channel control
// assumes a 200 MHz system clock (5 ns period)
`ifndef MDSH_PARAMS_SVH
`define MDSH_PARAMS_SVH

`define MDSH_CLK_PERIOD_PS 5000
`define MDSH_GLITCH_MIN_NS 90
`define MDSH_RESET_MAX_NS 200
`define MDSH_ACQ_MAX_US 16
// least low time: round up
`define MDSH_GLITCH_CYC ((`MDSH_GLITCH_MIN_NS*1000+`MDSH_CLK_PERIOD_PS-1)/`MDSH_CLK_PERIOD_PS)
// longest low time: round down
`define MDSH_RESET_CYC ((`MDSH_RESET_MAX_NS*1000)/`MDSH_CLK_PERIOD_PS)
`define MDSH_ACQ_CYC ((`MDSH_ACQ_MAX_US*1000000)/`MDSH_CLK_PERIOD_PS)
`define MDSH_NUM_CH 32
`define MDSH_CODE_W 14
`define MDSH_OFFSET_CH 6'h20
`define MDSH_CODE_RESET 14'h0000
`define MDSH_MODE_SHA 2'h0
`define MDSH_MODE_LOAD 2'h1
`define MDSH_MODE_ACQ_RB 2'h2
`define MDSH_MODE_RB 2'h3

`endif

// >>> pkg/mdsh_pkg.sv
// types for the dac channel control: commands, modes, states
// assumes the word framer delivers one decoded command per pulse
`include "mdsh_params.svh"
package mdsh_pkg;
	typedef enum logic [1:0] {
		MDSH_SHA    = 2'h0,
		MDSH_LOAD   = 2'h1,
		MDSH_ACQ_RB = 2'h2,
		MDSH_RB     = 2'h3
	} mdsh_mode_t;

	typedef enum logic [2:0] {
		MDSH_IDLE  = 3'h1,
		MDSH_TRACK = 3'h2,
		MDSH_ACQ   = 3'h4
	} mdsh_state_t;

	// one decoded serial word
	typedef struct packed {
		mdsh_mode_t  mode;
		logic [5:0]  chan;
		logic [13:0] code;
	} mdsh_cmd_t;
endpackage

// >>> tb/mdsh_ctrl_tb.sv
// self-checking bench for the dac channel control
// assumes ACQ_CYC shrunk to 20 and a 200 MHz clk
`timescale 1ns/1ps
`default_nettype none
module mdsh_ctrl_tb;
	import mdsh_pkg::*;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
$display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
	localparam int ACQ = 20;
	logic clk = 0, rstn = 0, trk = 1, req = 0, cmd_valid, busy_n, rb_v, off_o;
	mdsh_cmd_t word = '0, cmd;
	logic [13:0] adc = 14'h1abc, off_c, rb_c;
	logic [31:0][13:0] chc;
	logic [31:0] fol;
	logic [32:0] fol_all;
	int num_errors = 0, check_count = 0;
	mdsh_host i_mdsh_host (.clk(clk), .req(req), .word(word),
		.cmd_valid(cmd_valid), .cmd(cmd));
	mdsh_ctrl #(.ACQ_CYC(ACQ)) i_mdsh_ctrl (.clk(clk), .rstn(rstn),
		.cmd_valid(cmd_valid), .cmd(cmd), .track_reset_n(trk),
		.busy_n(busy_n), .adc_code(adc), .chan_code(chc),
		.offset_code(off_c), .follow_input(fol),
		.offset_channel_output(off_o), .readback_code(rb_c),
		.readback_valid(rb_v));
	// offset buffer flag beside the channel flags, indexed by address
	assign fol_all = {off_o, fol};
	// free-running 200 MHz clock
	initial forever #2.5 clk = ~clk;
	task automatic wrap_up();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic send(mdsh_mode_t m, logic [5:0] ch, logic [13:0] c);
		@(posedge clk);
		req <= 1'b1;
		word <= '{m, ch, c};
		@(posedge clk);
		req <= 1'b0;
		// return while the one-cycle readback pulse still stands
		tick(1);
	endtask
	// bounded wait on busy_n (sel 0) or readback_valid (sel 1)
	task automatic wait_for(input bit sel, input logic lvl);
		int n;
		n = 0;
		while ((sel ? rb_v : busy_n) !== lvl) begin
			tick(1);
			n++;
			if (n > 200) begin
				num_errors++;
				wrap_up();
			end
		end
	endtask
	// acquisition: buffer follows input while busy, busy lasts ACQ
	task automatic acq(int ch);
		int n;
		n = 0;
		wait_for(1'b0, 1'b0);
		`CHK(fol_all[ch], 1'b1)
		while (busy_n === 1'b0 && n < 300) begin
			tick(1);
			n++;
		end
		`CHK(n, ACQ)
		`CHK(fol_all[ch], 1'b0)
	endtask
	task automatic t_load();
		`CHK({chc, off_c, busy_n}, {462'h0, 1'b1})
		send(MDSH_LOAD, 6'd31, 14'h3fff);
		`CHK(chc[31:30], {14'h3fff, 14'h0})
		send(MDSH_LOAD, 6'h20, 14'h0155);
		`CHK(off_c, 14'h0155)
	endtask
	task automatic t_acq();
		send(MDSH_SHA, 6'd5, 14'h0);
		acq(5);
		`CHK(chc[5], 14'h1abc)
		@(posedge clk);
		adc <= 14'h0777;
		tick(10);
		`CHK(chc[5], 14'h1abc)
		send(MDSH_RB, 6'd5, 14'h0);
		`CHK({rb_v, rb_c}, {1'b1, 14'h1abc})
		send(MDSH_ACQ_RB, 6'd7, 14'h0);
		acq(7);
		wait_for(1'b1, 1'b1);
		`CHK(rb_c, 14'h0777)
	endtask
	// offset channel set by acquisition; its buffer follows the input
	task automatic t_offs();
		send(MDSH_SHA, 6'h20, 14'h0);
		acq(32);
		`CHK(off_c, 14'h0777)
		`CHK(chc[7], 14'h0777)
	endtask
	task automatic pin_low(int n);
		@(posedge clk);
		trk <= 1'b0;
		repeat (n) @(posedge clk);
		trk <= 1'b1;
		tick(8);
	endtask
	task automatic t_pin();
		pin_low(8);
		`CHK(chc[31], 14'h3fff)
		pin_low(30);
		`CHK({chc[31], chc[5], off_c}, 42'h0)
	endtask
	task automatic t_track();
		@(posedge clk);
		trk <= 1'b0;
		send(MDSH_SHA, 6'd2, 14'h0);
		tick(60);
		`CHK({fol[2], busy_n}, 2'h3)
		@(posedge clk);
		trk <= 1'b1;
		acq(2);
		`CHK(chc[2], 14'h0777)
	endtask
	// reset, then each scenario in turn
	initial begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		tick(6);
		t_load();
		t_acq();
		t_offs();
		t_pin();
		t_track();
		wrap_up();
	end
endmodule // mdsh_ctrl_tb
`default_nettype wire

// >>> tb/mdsh_host.sv
// host model: hands one decoded word to the block per request
// assumes the bench raises req for one clk with word already set
`timescale 1ns/1ps
`default_nettype none
module mdsh_host (
	// clock
	input  wire logic                clk,
	// bench request
	input  wire logic                req,
	input  wire mdsh_pkg::mdsh_cmd_t word,
	// word to the block
	output logic                     cmd_valid,
	output mdsh_pkg::mdsh_cmd_t      cmd
);
	import mdsh_pkg::*;
	// one word per pulse; once released the fields flip, not hold
	always @(posedge clk) begin
		cmd_valid <= req;
		cmd <= req ? word : ~cmd;
	end
endmodule // mdsh_host
`default_nettype wire
